/* bench/gom_pin_load.sv */
// Pull-down load seen by one general-purpose output pin
`timescale 1ns/1ps

module gom_pin_load (
  // Driver side
  input  wire  pinOut,
  input  wire  pinOutEn,
  // Sensed line
  output logic lineLevel
);
  // Released line sinks to the pull-down, never holds the last level
  assign lineLevel = pinOutEn ? pinOut : 1'b0;
endmodule // gom_pin_load

/* bench/gom_top_props.sv */
// Port-level checker for the two-pin output source multiplexer
`timescale 1ns/1ps

module gom_top_props (
  // Clock and reset
  input wire        clk,
  input wire        arst_n,
  // APB slave
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [9:0]  paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  // Pin drivers
  input wire        pin2Out,
  input wire        pin2OutEn,
  input wire        pin3Out,
  input wire        pin3OutEn
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  wire acc = psel && penable;
  wire wr2 = acc && pwrite && paddr == 10'h048 && pstrb[0];
  wire wr3 = acc && pwrite && paddr == 10'h04c && pstrb[0];

  a_zero_wait: assert property (acc |-> pready)
    else $error("access phase without ready");
  a_idle_rdata: assert property (!acc |-> prdata == 32'h0)
    else $error("read data outside access phase");
  a_misalign_err: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_ctl_mapped: assert property (acc && paddr == 10'h048 |->
    !pslverr && prdata[31:8] == 24'h0)
    else $error("pin control byte not mapped cleanly");
  a_rst_quiet: assert property ($rose(arst_n) |->
    !pin2OutEn && !pin3OutEn && !pin2Out && !pin3Out)
    else $error("pins active after reset");
  a_dis_low: assert property ((pin2OutEn || !pin2Out) &&
    (pin3OutEn || !pin3Out))
    else $error("disabled pin shows a high level");
  a_en_follow: assert property (wr2 |->
    ##2 pin2OutEn == $past(pwdata[0], 2))
    else $error("pin enable does not follow write");
  a_val_drive: assert property (wr2 && pwdata[7:2] == 6'h04
    && pwdata[0] |-> ##2 pin2Out == $past(pwdata[1], 2))
    else $error("register value not driven");
  a_resv_src: assert property (wr3 && pwdata[4:2] == 3'h5 && pwdata[0]
    |-> ##2 pin3OutEn && !pin3Out)
    else $error("reserved source not low");
  a_pin_indep: assert property (wr2 |-> ##2 $stable(pin3OutEn))
    else $error("pin 2 write disturbs pin 3");

  c_wr2: cover property (wr2);
  c_err: cover property (acc && pslverr);
  c_drive3: cover property (pin3OutEn && pin3Out);
endmodule // gom_top_props

bind gom_top gom_top_props u_props (
  .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .pin2Out(pin2Out), .pin2OutEn(pin2OutEn),
  .pin3Out(pin3Out), .pin3OutEn(pin3OutEn)
);

/* bench/gom_top_tb.sv */
// Self-checking testbench for the two-pin output source multiplexer
`timescale 1ns/1ps

module gom_top_tb;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0] pstrb, rxLock, rxPass, rxFrameValid, rxLineValid;
  logic [15:0] rxRemotePins;
  logic [1:0] txLineValid, txSync, txIrq;
  logic pin2Out, pin2OutEn, pin3Out, pin3OutEn, line2, line3, err;
  logic [3:0] rxEnMask, tx0Mask, tx1Mask;
  logic [7:0] c2, c3;
  int seed = 52509;
  int numErrors = 0;
  int totalChecks = 0;

  gom_top dut_u (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rxRemotePins(rxRemotePins), .rxLock(rxLock), .rxPass(rxPass),
    .rxFrameValid(rxFrameValid), .rxLineValid(rxLineValid),
    .txLineValid(txLineValid), .txSync(txSync), .txIrq(txIrq),
    .pin2Out(pin2Out), .pin2OutEn(pin2OutEn),
    .pin3Out(pin3Out), .pin3OutEn(pin3OutEn));
  gom_pin_load load2 (.pinOut(pin2Out), .pinOutEn(pin2OutEn),
    .lineLevel(line2));
  gom_pin_load load3 (.pinOut(pin3Out), .pinOutEn(pin3OutEn),
    .lineLevel(line3));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic expLvl(input logic [7:0] c);
    logic [3:0] m;
    int p;
    p = c[3:2];
    m = c[2] ? tx1Mask : tx0Mask;
    expLvl = 1'b0;
    if (!c[4]) begin
      case (c[7:5])
        3'h0: expLvl = rxRemotePins[4*p];
        3'h3: expLvl = rxRemotePins[4*p+3];
        3'h4: expLvl = rxLock[p];
        3'h5: expLvl = rxPass[p];
        3'h6: expLvl = rxFrameValid[p];
        3'h7: expLvl = rxLineValid[p];
      endcase
    end else if (c[4:2] == 3'h4) begin
      case (c[7:5])
        3'h0: expLvl = c[1];
        3'h1: expLvl = |(rxLock & rxEnMask);
        3'h2: expLvl = rxEnMask != 4'h0 && &(rxLock | ~rxEnMask);
      endcase
    end else if (c[3]) begin
      case (c[7:5])
        3'h0: expLvl = m != 4'h0 && &(rxPass | ~m);
        3'h1: expLvl = |(rxPass & m);
        3'h3: expLvl = txLineValid[c[2]];
        3'h4: expLvl = txSync[c[2]];
        3'h5: expLvl = txIrq[c[2]];
      endcase
    end
  endfunction

  // Status word: pins, then pass OR/AND per transmit port, lock AND/OR
  function automatic logic [31:0] expStatus();
    expStatus = {20'h0, c3[0], c3[0] & expLvl(c3),
                 c2[0], c2[0] & expLvl(c2),
                 expLvl(8'h3c), expLvl(8'h38), expLvl(8'h1c), expLvl(8'h18),
                 expLvl(8'h50), expLvl(8'h30), 2'h0};
  endfunction

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    // No timeout here; only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrReg(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
    check("write error", 32'h0, {31'h0, err});
  endtask

  task automatic rdChk(input logic [9:0] a, input logic [31:0] exp,
                       input logic expErr);
    apb(1'b0, a, 32'h0, 4'h0);
    check("read data", exp, rd);
    check("read error", {31'h0, expErr}, {31'h0, err});
  endtask

  task automatic pinChk;
    check("pin2", {c2[0], c2[0] & expLvl(c2)}, {pin2OutEn, pin2Out});
    check("pin3", {c3[0], c3[0] & expLvl(c3)}, {pin3OutEn, pin3Out});
    check("line2", {31'h0, c2[0] & expLvl(c2)}, {31'h0, line2});
    check("line3", {31'h0, c3[0] & expLvl(c3)}, {31'h0, line3});
  endtask

  task testDone;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {rxRemotePins, rxLock, rxPass, rxFrameValid, rxLineValid} = '0;
    {txLineValid, txSync, txIrq} = '0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rdChk(10'h048, 32'h0, 1'b0);
    rdChk(10'h04c, 32'h0, 1'b0);
    rdChk(10'h000, 32'h0, 1'b1);
    rdChk(10'h049, 32'h0, 1'b1);
    apb(1'b1, 10'h048, 32'hff, 4'he);
    rdChk(10'h048, 32'h0, 1'b0);
    for (int i = 0; i < 256; i++) begin
      c2 = i[7:0];
      c3 = c2 * 8'd37 + 8'd5;
      r = $random(seed);
      rxEnMask = r[3:0];
      tx0Mask = r[7:4];
      tx1Mask = r[11:8];
      wrReg(10'h080, {28'h0, rxEnMask});
      wrReg(10'h084, {28'h0, tx0Mask});
      wrReg(10'h088, {28'h0, tx1Mask});
      wrReg(10'h048, {r[31:8], c2});
      wrReg(10'h04c, {24'h0, c3});
      rdChk(10'h048, {24'h0, c2}, 1'b0);
      r = $random(seed);
      @(posedge clk);
      {txIrq, txSync, txLineValid, rxLineValid} <= r[25:16];
      {rxFrameValid, rxPass, rxLock} <= r[15:4];
      rxRemotePins <= r[15:0] ^ r[31:16];
      repeat (3) @(posedge clk);
      pinChk;
      rdChk(10'h08c, expStatus(), 1'b0);
    end
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    c2 = 8'h00;
    c3 = 8'h00;
    pinChk;
    rdChk(10'h04c, 32'h0, 1'b0);
    testDone;
  end

  initial begin
    #1000000;
    numErrors++;
    testDone;
  end
endmodule // gom_top_tb

/* src/gom_consts.vh */
// Constants for the two-pin output source multiplexer
// Function
// [R1] Source 4:2: 000-011 receive, 100 status, 101 reserved, 11x transmit.
// [R2] Pin driven only while enable bit 0 is 1; resets to 0, disabled.
// [R3] Register-value selection drives the value bit 1, which resets to 0.
// [R4] Receive source: 100 lock, 101 pass, 110 frame valid, 111 line valid.
// [R5] Receive source select 000 outputs remote pin 0 from that port.
// [R6] Receive source select 011 outputs remote pin 3 from that port.
// [R7] Status source: 000 value bit, 001 OR of enabled locks, 010 AND.
// [R8] Transmit source: 000 AND of selected ports' pass, 001 OR of them.
// [R9] Transmit source select 011 outputs the transmit line-valid indication.
// [R10] Transmit source: 100 synchronized, 101 interrupt, 111 reserved.
// [R11] Pin 2 control byte sits at index 0x12, below pin 3 at 0x13.
// [R12] Pin 2 and pin 3 bytes independent; garbled select codes are reserved.
`ifndef GOM_CONSTS_VH
`define GOM_CONSTS_VH

// ----------------------------------------------------------------
// Register indices and address width
// ----------------------------------------------------------------
`define GOM_IDX_PIN2_CTL   8'h12
`define GOM_IDX_PIN3_CTL   8'h13
`define GOM_IDX_RX_ENABLE  8'h20
`define GOM_IDX_TX0_RXSEL  8'h21
`define GOM_IDX_TX1_RXSEL  8'h22
`define GOM_IDX_STATUS     8'h23
`define GOM_ADDR_W         10

// ----------------------------------------------------------------
// Control byte fields
// ----------------------------------------------------------------
`define GOM_EN_BIT         0
`define GOM_VAL_BIT        1
`define GOM_SRC_LSB        2
`define GOM_SRC_MSB        4
`define GOM_SEL_LSB        5
`define GOM_SEL_MSB        7
`define GOM_CTL_RESET      8'h00
`define GOM_MASK_RESET     4'h0

// ----------------------------------------------------------------
// Source codes
// ----------------------------------------------------------------
`define GOM_SRC_STATUS     3'h4
`define GOM_SRC_RESV       3'h5
`define GOM_SRC_TX0        3'h6
`define GOM_SRC_TX1        3'h7

// ----------------------------------------------------------------
// Signal select codes
// ----------------------------------------------------------------
`define GOM_RX_PIN0        3'h0
`define GOM_RX_PIN3        3'h3
`define GOM_RX_LOCK        3'h4
`define GOM_RX_PASS        3'h5
`define GOM_RX_FV          3'h6
`define GOM_RX_LV          3'h7
`define GOM_ST_VALUE       3'h0
`define GOM_ST_LOCK_OR     3'h1
`define GOM_ST_LOCK_AND    3'h2
`define GOM_TX_PASS_AND    3'h0
`define GOM_TX_PASS_OR     3'h1
`define GOM_TX_LV          3'h3
`define GOM_TX_SYNC        3'h4
`define GOM_TX_IRQ         3'h5

`endif

/* src/gom_pin_mux.v */
// Source and signal selection for one output pin
`timescale 1ns/1ps
`include "gom_consts.vh"

module gom_pin_mux (
  // Control byte of this pin
  input  wire [7:0]  ctl,
  // Receive port signals
  input  wire [15:0] rxRemotePins,
  input  wire [3:0]  rxLock,
  input  wire [3:0]  rxPass,
  input  wire [3:0]  rxFrameValid,
  input  wire [3:0]  rxLineValid,
  // Aggregated status
  input  wire        devLockOr,
  input  wire        devLockAnd,
  input  wire [1:0]  txPassAnd,
  input  wire [1:0]  txPassOr,
  // Transmit port signals
  input  wire [1:0]  txLineValid,
  input  wire [1:0]  txSync,
  input  wire [1:0]  txIrq,
  // Selected level
  output reg         level
);

  wire [2:0] srcSel = ctl[`GOM_SRC_MSB:`GOM_SRC_LSB];
  wire [2:0] sigSel = ctl[`GOM_SEL_MSB:`GOM_SEL_LSB];
  wire       tx     = srcSel[0];

  // Bit of a four-wide vector picked by a port number
  function pick4;
    input [3:0] vec;
    input [1:0] idx;
    begin
      pick4 = vec[idx];
    end
  endfunction

  always @* begin
    level = 1'b0;
    if (srcSel[2] == 1'b0) begin // [R1]
      case (sigSel)
        `GOM_RX_PIN0: level = rxRemotePins[{srcSel[1:0], 2'h0}]; // [R5]
        `GOM_RX_PIN3: level = rxRemotePins[{srcSel[1:0], 2'h3}]; // [R6]
        `GOM_RX_LOCK: level = pick4(rxLock, srcSel[1:0]); // [R4]
        `GOM_RX_PASS: level = pick4(rxPass, srcSel[1:0]); // [R4]
        `GOM_RX_FV:   level = pick4(rxFrameValid, srcSel[1:0]); // [R4]
        `GOM_RX_LV:   level = pick4(rxLineValid, srcSel[1:0]); // [R4]
        default:      level = 1'b0; // [R12]
      endcase
    end else if (srcSel == `GOM_SRC_STATUS) begin // [R1]
      case (sigSel)
        `GOM_ST_VALUE:    level = ctl[`GOM_VAL_BIT]; // [R3] [R7]
        `GOM_ST_LOCK_OR:  level = devLockOr; // [R7]
        `GOM_ST_LOCK_AND: level = devLockAnd; // [R7]
        default:          level = 1'b0; // [R12]
      endcase
    end else if (srcSel != `GOM_SRC_RESV) begin // [R1]
      case (sigSel)
        `GOM_TX_PASS_AND: level = txPassAnd[tx]; // [R8]
        `GOM_TX_PASS_OR:  level = txPassOr[tx]; // [R8]
        `GOM_TX_LV:       level = txLineValid[tx]; // [R9]
        `GOM_TX_SYNC:     level = txSync[tx]; // [R10]
        `GOM_TX_IRQ:      level = txIrq[tx]; // [R10]
        default:          level = 1'b0; // [R10] [R12]
      endcase
    end
  end

endmodule // gom_pin_mux

/* src/gom_top.v */
// Two-pin output source multiplexer with APB register slave
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`include "gom_consts.vh"

module gom_top (
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [9:0]  paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Receive port signals
  input  wire [15:0] rxRemotePins,
  input  wire [3:0]  rxLock,
  input  wire [3:0]  rxPass,
  input  wire [3:0]  rxFrameValid,
  input  wire [3:0]  rxLineValid,
  // Transmit port signals
  input  wire [1:0]  txLineValid,
  input  wire [1:0]  txSync,
  input  wire [1:0]  txIrq,
  // Pin 2 output driver
  output wire        pin2Out,
  output wire        pin2OutEn,
  // Pin 3 output driver
  output wire        pin3Out,
  output wire        pin3OutEn
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg  [7:0] pin2OutputControl_q;
  reg  [7:0] pin3OutputControl_q;
  reg  [3:0] rxEnable_q;
  reg  [3:0] tx0RxSel_q;
  reg  [3:0] tx1RxSel_q;
  reg  [7:0] pin2OutputControl_d;
  reg  [7:0] pin3OutputControl_d;
  reg  [3:0] rxEnable_d;
  reg  [3:0] tx0RxSel_d;
  reg  [3:0] tx1RxSel_d;

  // Pin drivers held in flops
  reg        pin2Out_q;
  reg        pin2OutEn_q;
  reg        pin3Out_q;
  reg        pin3OutEn_q;

  wire       pin2Level;
  wire       pin3Level;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  // Printed offsets are word indices; byte address is four times that
  wire [7:0] wordIdx  = paddr[9:2];
  wire       aligned  = (paddr[1:0] == 2'h0);
  wire       access   = psel & penable;
  wire       wrStrobe = access & pwrite;

  // Index recognised by this slave
  function isMapped;
    input [7:0] idx;
    begin
      case (idx)
        `GOM_IDX_PIN2_CTL:  isMapped = 1'b1;
        `GOM_IDX_PIN3_CTL:  isMapped = 1'b1;
        `GOM_IDX_RX_ENABLE: isMapped = 1'b1;
        `GOM_IDX_TX0_RXSEL: isMapped = 1'b1;
        `GOM_IDX_TX1_RXSEL: isMapped = 1'b1;
        `GOM_IDX_STATUS:    isMapped = 1'b1;
        default:            isMapped = 1'b0;
      endcase
    end
  endfunction

  wire       hit    = aligned & isMapped(wordIdx);
  wire       wrLane = pstrb[0];
  wire       doWr   = wrStrobe & hit & wrLane;

  // Zero wait states keeps the master simple
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;

  // ----------------------------------------------------------------
  // Aggregated status terms
  // ----------------------------------------------------------------
  // AND terms need at least one contributor, else they read low
  wire       anyRxEn    = |rxEnable_q;
  wire       devLockOr  = |(rxLock & rxEnable_q); // [R7]
  wire       devLockAnd = anyRxEn & (&(rxLock | ~rxEnable_q)); // [R7]
  wire [1:0] txPassAnd;
  wire [1:0] txPassOr;

  assign txPassAnd[0] = (|tx0RxSel_q) & (&(rxPass | ~tx0RxSel_q)); // [R8]
  assign txPassAnd[1] = (|tx1RxSel_q) & (&(rxPass | ~tx1RxSel_q)); // [R8]
  assign txPassOr[0]  = |(rxPass & tx0RxSel_q); // [R8]
  assign txPassOr[1]  = |(rxPass & tx1RxSel_q); // [R8]

  // ----------------------------------------------------------------
  // Register write path
  // ----------------------------------------------------------------
  always @* begin
    pin2OutputControl_d = pin2OutputControl_q;
    pin3OutputControl_d = pin3OutputControl_q;
    rxEnable_d          = rxEnable_q;
    tx0RxSel_d          = tx0RxSel_q;
    tx1RxSel_d          = tx1RxSel_q;
    if (doWr) begin
      case (wordIdx)
        `GOM_IDX_PIN2_CTL:  pin2OutputControl_d = pwdata[7:0]; // [R11] [R12]
        `GOM_IDX_PIN3_CTL:  pin3OutputControl_d = pwdata[7:0]; // [R12]
        `GOM_IDX_RX_ENABLE: rxEnable_d          = pwdata[3:0];
        `GOM_IDX_TX0_RXSEL: tx0RxSel_d          = pwdata[3:0];
        `GOM_IDX_TX1_RXSEL: tx1RxSel_d          = pwdata[3:0];
        default:            rxEnable_d          = rxEnable_q;
      endcase
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin2OutputControl_q <= `GOM_CTL_RESET; // [R2] [R3]
      pin3OutputControl_q <= `GOM_CTL_RESET; // [R2] [R3]
      rxEnable_q          <= `GOM_MASK_RESET;
      tx0RxSel_q          <= `GOM_MASK_RESET;
      tx1RxSel_q          <= `GOM_MASK_RESET;
    end else begin
      pin2OutputControl_q <= pin2OutputControl_d;
      pin3OutputControl_q <= pin3OutputControl_d;
      rxEnable_q          <= rxEnable_d;
      tx0RxSel_q          <= tx0RxSel_d;
      tx1RxSel_q          <= tx1RxSel_d;
    end
  end

  // ----------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------
  // Status word shows live aggregate terms and the pin drivers
  wire [31:0] statusWord = {20'h00000,
                            pin3OutEn_q, pin3Out_q,
                            pin2OutEn_q, pin2Out_q,
                            txPassOr, txPassAnd,
                            devLockAnd, devLockOr,
                            2'h0};

  reg  [31:0] readWord;

  always @* begin
    readWord = 32'h00000000;
    case (wordIdx)
      `GOM_IDX_PIN2_CTL:  readWord = {24'h000000, pin2OutputControl_q};
      `GOM_IDX_PIN3_CTL:  readWord = {24'h000000, pin3OutputControl_q};
      `GOM_IDX_RX_ENABLE: readWord = {28'h0000000, rxEnable_q};
      `GOM_IDX_TX0_RXSEL: readWord = {28'h0000000, tx0RxSel_q};
      `GOM_IDX_TX1_RXSEL: readWord = {28'h0000000, tx1RxSel_q};
      `GOM_IDX_STATUS:    readWord = statusWord;
      default:            readWord = 32'h00000000;
    endcase
  end

  // Loaded in the setup phase; status bits lag by one cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable & ~pwrite & aligned) begin
      prdata <= readWord;
    end else begin
      prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Per-pin selection
  // ----------------------------------------------------------------
  gom_pin_mux uPin2Mux (
    .ctl          (pin2OutputControl_q),
    .rxRemotePins (rxRemotePins),
    .rxLock       (rxLock),
    .rxPass       (rxPass),
    .rxFrameValid (rxFrameValid),
    .rxLineValid  (rxLineValid),
    .devLockOr    (devLockOr),
    .devLockAnd   (devLockAnd),
    .txPassAnd    (txPassAnd),
    .txPassOr     (txPassOr),
    .txLineValid  (txLineValid),
    .txSync       (txSync),
    .txIrq        (txIrq),
    .level        (pin2Level)
  );

  gom_pin_mux uPin3Mux (
    .ctl          (pin3OutputControl_q),
    .rxRemotePins (rxRemotePins),
    .rxLock       (rxLock),
    .rxPass       (rxPass),
    .rxFrameValid (rxFrameValid),
    .rxLineValid  (rxLineValid),
    .devLockOr    (devLockOr),
    .devLockAnd   (devLockAnd),
    .txPassAnd    (txPassAnd),
    .txPassOr     (txPassOr),
    .txLineValid  (txLineValid),
    .txSync       (txSync),
    .txIrq        (txIrq),
    .level        (pin3Level)
  );

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Level forced low while disabled so a later enable starts clean
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin2Out_q   <= 1'b0;
      pin2OutEn_q <= 1'b0;
      pin3Out_q   <= 1'b0;
      pin3OutEn_q <= 1'b0;
    end else begin
      pin2OutEn_q <= pin2OutputControl_q[`GOM_EN_BIT]; // [R2]
      pin2Out_q   <= pin2OutputControl_q[`GOM_EN_BIT] & pin2Level; // [R2]
      pin3OutEn_q <= pin3OutputControl_q[`GOM_EN_BIT]; // [R2]
      pin3Out_q   <= pin3OutputControl_q[`GOM_EN_BIT] & pin3Level; // [R2]
    end
  end

  assign pin2Out   = pin2Out_q;
  assign pin2OutEn = pin2OutEn_q;
  assign pin3Out   = pin3Out_q;
  assign pin3OutEn = pin3OutEn_q;

endmodule // gom_top
